// *** shared/rioc_pkg.sv ***
// Constants, types and register map of the residual instantaneous overcurrent block
package rioc_pkg;

	// ************************************************************
	// Widths
	// ************************************************************
	localparam int unsigned MEAS_W = 16;
	localparam int unsigned SET_W  = 12;
	localparam int unsigned THR_W  = 13;
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned IRQ_W  = 2;

	// ************************************************************
	// Start current setting, in percent of nominal current
	// ************************************************************
	localparam logic [SET_W-1:0] START_MIN     = 12'h00A;
	localparam logic [SET_W-1:0] START_MAX_STD = 12'h3E8;
	localparam logic [SET_W-1:0] START_MAX_EXT = 12'hBB8;
	localparam logic [SET_W-1:0] START_DEF     = 12'h0C8;

	// ************************************************************
	// Operation setting, Gray coded along off, peak, fundamental
	// ************************************************************
	typedef enum logic [1:0]
	{
		OP_OFF  = 2'h0,
		OP_PEAK = 2'h1,
		OP_FUND = 2'h3
	} op_mode_e;

	// ************************************************************
	// Register map, byte offsets
	// ************************************************************
	localparam logic [ADDR_W-1:0] REG_CTRL     = 5'h00;
	localparam logic [ADDR_W-1:0] REG_START    = 5'h04;
	localparam logic [ADDR_W-1:0] REG_STATUS   = 5'h08;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 5'h0C;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 5'h10;

	// Status register bit positions
	localparam int unsigned ST_INT_TRIP = 0;
	localparam int unsigned ST_GEN_TRIP = 1;
	localparam int unsigned ST_BLOCK    = 2;
	localparam int unsigned ST_DOUBLE   = 3;
	localparam int unsigned ST_EXT      = 4;

	// Interrupt status and mask bit positions
	localparam int unsigned IRQ_TRIP_ON  = 0;
	localparam int unsigned IRQ_TRIP_OFF = 1;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ************************************************************
	// Measurement carrier from the front end
	// ************************************************************
	typedef struct packed
	{
		logic              valid;
		logic [MEAS_W-1:0] peak;
		logic [MEAS_W-1:0] fund;
	} meas_s;

endpackage

// *** logic/residual_inst_overcurrent.sv ***
// Residual instantaneous overcurrent decision, trip logic and register slave
`timescale 1ns/1ns

// What this block does
// - Internal trip rises with no timer once selected measure exceeds threshold.
// - Operation selects off, peak or fundamental measure; off after reset.
// - Start current in percent, unit steps, standard range, default two hundred.
// - With extended current module fitted, setting reaches the extended upper limit.
// - Threshold-doubling input makes the comparison use twice the setting.
// - Block input suppresses the general trip whatever the internal trip does.
// - General trip combines internal trip, block status and operation setting.
module residual_inst_overcurrent
	import rioc_pkg::*;
(
	input  wire  logic                         clk,
	input  wire  logic                         rst,
	input  wire  rioc_pkg::meas_s              meas,
	input  wire  logic                         threshold_double_in,
	input  wire  logic                         trip_block_in,
	input  wire  logic                         ext_module_fitted,
	output logic                               internal_trip,
	output logic                               general_trip_out,
	output logic                               irq,
	input  wire  logic [rioc_pkg::ADDR_W-1:0]  awaddr,
	input  wire  logic                         awvalid,
	output logic                               awready,
	input  wire  logic [rioc_pkg::DATA_W-1:0]  wdata,
	input  wire  logic [3:0]                   wstrb,
	input  wire  logic                         wvalid,
	output logic                               wready,
	output logic [1:0]                         bresp,
	output logic                               bvalid,
	input  wire  logic                         bready,
	input  wire  logic [rioc_pkg::ADDR_W-1:0]  araddr,
	input  wire  logic                         arvalid,
	output logic                               arready,
	output logic [rioc_pkg::DATA_W-1:0]        rdata,
	output logic [1:0]                         rresp,
	output logic                               rvalid,
	input  wire  logic                         rready
);
	import rioc_pkg::*;

	// ************************************************************
	// Helpers
	// ************************************************************
	// The low two address bits are ignored for decode; byte lanes come from the write strobes only
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
		return a[ADDR_W-1:2] == r[ADDR_W-1:2];
	endfunction

	function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v, input logic [3:0] strb);
		logic [DATA_W-1:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				res[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return res;
	endfunction

	// ************************************************************
	// Strap synchroniser for the fitted current module
	// ************************************************************
	logic ext_meta_q;
	logic ext_sync_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ext_meta_q <= 1'b0;
			ext_sync_q <= 1'b0;
		end
		else
		begin
			ext_meta_q <= ext_module_fitted;
			ext_sync_q <= ext_meta_q;
		end
	end

	// ************************************************************
	// Settings and decision
	// ************************************************************
	op_mode_e           mode_q, mode_d;
	logic [SET_W-1:0]   start_q, start_d;
	logic [SET_W-1:0]   start_lim;
	logic [THR_W-1:0]   thr;
	logic [MEAS_W-1:0]  measure;
	logic               itrip_q, itrip_d;
	logic               gtrip_q, gtrip_d;

	always_comb
	begin
		// Out-of-range settings are clamped at use, so a later strap change still holds
		start_lim = start_q;
		if (start_lim < START_MIN)
			start_lim = START_MIN;
		if (ext_sync_q && start_lim > START_MAX_EXT)
			start_lim = START_MAX_EXT;
		else if (!ext_sync_q && start_lim > START_MAX_STD)
			start_lim = START_MAX_STD;
		thr = threshold_double_in ? {start_lim, 1'b0} : {1'b0, start_lim};
		unique case (mode_q)
			OP_PEAK: measure = meas.peak;
			OP_FUND: measure = meas.fund;
			default: measure = '0;
		endcase
		itrip_d = itrip_q;
		if (mode_q == OP_OFF)
			itrip_d = 1'b0;
		else if (meas.valid)
			itrip_d = measure > MEAS_W'(thr);
		gtrip_d = itrip_q && !trip_block_in && mode_q != OP_OFF;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			itrip_q <= 1'b0;
			gtrip_q <= 1'b0;
		end
		else
		begin
			itrip_q <= itrip_d;
			gtrip_q <= gtrip_d;
		end
	end

	assign internal_trip    = itrip_q;
	assign general_trip_out = gtrip_q;

	// ************************************************************
	// Register slave and interrupts
	// ************************************************************
	logic                     aw_full_q, aw_full_d;
	logic                     w_full_q, w_full_d;
	logic [ADDR_W-1:0]        aw_addr_q, aw_addr_d;
	logic [DATA_W-1:0]        w_data_q, w_data_d;
	logic [3:0]               w_strb_q, w_strb_d;
	logic                     awready_q, awready_d, wready_q, wready_d;
	logic                     bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0]               bresp_q, bresp_d, rresp_q, rresp_d;
	logic [DATA_W-1:0]        rdata_q, rdata_d;
	logic [IRQ_W-1:0]         istat_q, istat_d, imask_q, imask_d, iset, iclr;
	logic                     irq_q, irq_d;
	logic                     do_wr;
	logic [DATA_W-1:0]        wr_val;

	always_comb
	begin
		aw_full_d = aw_full_q;
		w_full_d  = w_full_q;
		aw_addr_d = aw_addr_q;
		w_data_d  = w_data_q;
		w_strb_d  = w_strb_q;
		bvalid_d  = bvalid_q && !bready;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q && !rready;
		rresp_d   = rresp_q;
		rdata_d   = rdata_q;
		mode_d    = mode_q;
		start_d   = start_q;
		imask_d   = imask_q;
		iclr      = '0;
		wr_val    = '0;
		if (awvalid && awready_q)
		begin
			aw_full_d = 1'b1;
			aw_addr_d = awaddr;
		end
		if (wvalid && wready_q)
		begin
			w_full_d = 1'b1;
			w_data_d = wdata;
			w_strb_d = wstrb;
		end
		do_wr = aw_full_q && w_full_q && !bvalid_q;
		if (do_wr)
		begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = RESP_OKAY;
			if (reg_hit(aw_addr_q, REG_CTRL))
			begin
				wr_val = lane_merge(DATA_W'(mode_q), w_data_q, w_strb_q);
				// Unused code is refused so the setting never leaves a legal value
				if (wr_val[1:0] inside {OP_OFF, OP_PEAK, OP_FUND})
					mode_d = op_mode_e'(wr_val[1:0]);
			end
			else if (reg_hit(aw_addr_q, REG_START))
			begin
				wr_val  = lane_merge(DATA_W'(start_q), w_data_q, w_strb_q);
				start_d = wr_val[SET_W-1:0];
			end
			else if (reg_hit(aw_addr_q, REG_IRQ_STAT))
				iclr = w_strb_q[0] ? w_data_q[IRQ_W-1:0] : '0;
			else if (reg_hit(aw_addr_q, REG_IRQ_MASK))
			begin
				if (w_strb_q[0])
					imask_d = w_data_q[IRQ_W-1:0];
			end
			else if (!reg_hit(aw_addr_q, REG_STATUS))
				bresp_d = RESP_SLVERR;
		end
		if (arvalid && arready_q)
		begin
			rvalid_d = 1'b1;
			rresp_d  = RESP_OKAY;
			rdata_d  = '0;
			if (reg_hit(araddr, REG_CTRL))
				rdata_d = DATA_W'(mode_q);
			else if (reg_hit(araddr, REG_START))
				rdata_d = DATA_W'(start_q);
			else if (reg_hit(araddr, REG_STATUS))
			begin
				rdata_d[ST_INT_TRIP] = itrip_q;
				rdata_d[ST_GEN_TRIP] = gtrip_q;
				rdata_d[ST_BLOCK]    = trip_block_in;
				rdata_d[ST_DOUBLE]   = threshold_double_in;
				rdata_d[ST_EXT]      = ext_sync_q;
			end
			else if (reg_hit(araddr, REG_IRQ_STAT))
				rdata_d = DATA_W'(istat_q);
			else if (reg_hit(araddr, REG_IRQ_MASK))
				rdata_d = DATA_W'(imask_q);
			else
				rresp_d = RESP_SLVERR;
		end
		// Edges of the general trip are the events; a set in the clearing cycle survives
		iset               = '0;
		iset[IRQ_TRIP_ON]  = gtrip_d && !gtrip_q;
		iset[IRQ_TRIP_OFF] = !gtrip_d && gtrip_q;
		istat_d            = (istat_q & ~iclr) | iset;
		irq_d              = |(istat_d & imask_d);
		awready_d          = !aw_full_d && !bvalid_d;
		wready_d           = !w_full_d && !bvalid_d;
		arready_d          = !rvalid_d;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rresp_q   <= RESP_OKAY;
			rdata_q   <= '0;
			mode_q    <= OP_OFF;
			start_q   <= START_DEF;
			istat_q   <= '0;
			imask_q   <= '0;
			irq_q     <= 1'b0;
		end
		else
		begin
			aw_full_q <= aw_full_d;
			w_full_q  <= w_full_d;
			aw_addr_q <= aw_addr_d;
			w_data_q  <= w_data_d;
			w_strb_q  <= w_strb_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rresp_q   <= rresp_d;
			rdata_q   <= rdata_d;
			mode_q    <= mode_d;
			start_q   <= start_d;
			istat_q   <= istat_d;
			imask_q   <= imask_d;
			irq_q     <= irq_d;
		end
	end

	assign awready = awready_q;
	assign wready  = wready_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;
	assign arready = arready_q;
	assign rvalid  = rvalid_q;
	assign rresp   = rresp_q;
	assign rdata   = rdata_q;
	assign irq     = irq_q;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	trip_on_exceed_a: assert property (meas.valid && mode_q == OP_PEAK &&
		meas.peak > MEAS_W'(thr) |=> itrip_q)
		else $error("internal trip missed an exceeding peak");
	off_no_trip_a: assert property (mode_q == OP_OFF |=> !itrip_q ##1 !gtrip_q)
		else $error("trip seen while function is off");
	fund_select_a: assert property (meas.valid && mode_q == OP_FUND &&
		meas.fund <= MEAS_W'(thr) |=> !itrip_q)
		else $error("fundamental mode tripped at or below threshold");
	start_range_a: assert property (start_lim >= START_MIN &&
		start_lim <= (ext_sync_q ? START_MAX_EXT : START_MAX_STD))
		else $error("effective start current out of range");
	ext_limit_a: assert property (!ext_sync_q |-> start_lim <= START_MAX_STD)
		else $error("extended limit used without module");
	double_thr_a: assert property (threshold_double_in && meas.valid &&
		mode_q != OP_OFF && measure <= (MEAS_W'(start_lim) << 1) |=> !itrip_q)
		else $error("tripped at or below the doubled threshold");
	block_gate_a: assert property (trip_block_in |=> !gtrip_q)
		else $error("general trip while blocked");
	gen_follow_a: assert property (itrip_q && !trip_block_in && mode_q != OP_OFF
		|=> gtrip_q)
		else $error("general trip did not follow internal trip");
	trip_release_a: assert property (meas.valid && mode_q != OP_OFF &&
		measure <= MEAS_W'(thr) |=> !itrip_q ##1 (!gtrip_q || $past(itrip_q)))
		else $error("trip held after measure fell");
	irq_level_a: assert property ($rose(gtrip_q) |-> istat_q[IRQ_TRIP_ON])
		else $error("trip rise not latched");

	peak_trip_c: cover property (mode_q == OP_PEAK && $rose(gtrip_q));
	fund_trip_c: cover property (mode_q == OP_FUND && threshold_double_in && $rose(itrip_q));
	blocked_trip_c: cover property (itrip_q && trip_block_in [*3]);
	irq_clear_c: cover property (irq_q ##[1:20] !irq_q);

endmodule // residual_inst_overcurrent

// *** dv/meas_front_end.sv ***
// Front-end model that supplies residual peak and fundamental RMS updates
`timescale 1ns/1ns

// ************************************************************
// Measurement source
// ************************************************************
module meas_front_end
	import rioc_pkg::*;
(
	input  wire logic        clk,
	output rioc_pkg::meas_s  meas
);
	initial meas = '0;

	// One valid cycle per update, then the data lines are inverted so a stale value never matches
	task automatic send(input logic [MEAS_W-1:0] pk, input logic [MEAS_W-1:0] fd);
		@(posedge clk);
		meas <= '{valid: 1'b1, peak: pk, fund: fd};
		@(posedge clk);
		meas <= '{valid: 1'b0, peak: ~pk, fund: ~fd};
	endtask
endmodule // meas_front_end

// *** dv/test_residual_inst_overcurrent.sv ***
// Self-checking bench for the residual instantaneous overcurrent block
`timescale 1ns/1ns

module test_residual_inst_overcurrent
	import rioc_pkg::*;
;
	logic              clk, rst, dbl, blk, ext, it, gt, irq;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [DATA_W-1:0] wdata, rdata;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp;
	meas_s             meas;
	int                errors, num_checks;

	meas_front_end i_meas_front_end (.clk(clk), .meas(meas));

	residual_inst_overcurrent i_residual_inst_overcurrent (
		.clk(clk), .rst(rst), .meas(meas), .threshold_double_in(dbl), .trip_block_in(blk),
		.ext_module_fitted(ext), .internal_trip(it), .general_trip_out(gt), .irq(irq),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));

	// ************************************************************
	// Checking and bus tasks
	// ************************************************************
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while ((awvalid && !awready) || (wvalid && !wready));
		do
			@(posedge clk);
		while (!bvalid);
		chk("bresp", {30'h0, bresp}, {30'h0, er});
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do
			@(posedge clk);
		while (!arready);
		arvalid <= 1'b0;
		do
			@(posedge clk);
		while (!rvalid);
		chk("rdata", rdata, ed);
		chk("rresp", {30'h0, rresp}, {30'h0, er});
		rready <= 1'b0;
	endtask

	// Flags f are {double, block, module fitted}; e is {internal trip, general trip}
	task automatic apply(input logic [1:0] m, input logic [11:0] s, input logic [2:0] f,
		input logic [15:0] pk, input logic [15:0] fd, input logic [1:0] e);
		wr(REG_CTRL, {30'h0, m}, 4'hF, RESP_OKAY);
		wr(REG_START, {20'h0, s}, 4'hF, RESP_OKAY);
		dbl <= f[2];
		blk <= f[1];
		ext <= f[0];
		// Module strap passes two flops, so let it settle before the update
		repeat (3)
			@(posedge clk);
		i_meas_front_end.send(pk, fd);
		repeat (2)
			@(posedge clk);
		#1;
		chk("internal_trip", {31'h0, it}, {31'h0, e[1]});
		chk("general_trip_out", {31'h0, gt}, {31'h0, e[0]});
	endtask

	task automatic irq_chk(input logic e);
		repeat (2)
			@(posedge clk);
		#1;
		chk("irq", {31'h0, irq}, {31'h0, e});
	endtask

	task automatic complete_run();
		if (errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ************************************************************
	// Clock, watchdog and test sequence
	// ************************************************************
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial
	begin
		repeat (20000)
			@(posedge clk);
		errors++;
		complete_run();
	end

	initial
	begin
		errors = 0;
		num_checks = 0;
		{rst, dbl, blk, ext, awvalid, wvalid, bready, arvalid, rready} = 9'h100;
		{awaddr, araddr, wdata, wstrb} = '0;
		repeat (10)
			@(posedge clk);
		rst <= 1'b0;
		repeat (3)
			@(posedge clk);
		rd(REG_CTRL, 32'h0, RESP_OKAY);
		rd(REG_START, 32'h000000C8, RESP_OKAY);
		rd(REG_IRQ_MASK, 32'h0, RESP_OKAY);
		rd(5'h14, 32'h0, RESP_SLVERR);
		wr(5'h14, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
		apply(OP_OFF, 12'h0C8, 3'h0, 16'h01F4, 16'h01F4, 2'h0);
		apply(OP_PEAK, 12'h0C8, 3'h0, 16'h00C8, 16'hFFFF, 2'h0);
		apply(OP_PEAK, 12'h0C8, 3'h0, 16'h00C9, 16'h0000, 2'h3);
		apply(OP_PEAK, 12'h0C8, 3'h0, 16'h00C8, 16'h0000, 2'h0);
		apply(OP_FUND, 12'h0C8, 3'h0, 16'h01F4, 16'h00C8, 2'h0);
		apply(OP_FUND, 12'h0C8, 3'h0, 16'h0000, 16'h00C9, 2'h3);
		apply(OP_PEAK, 12'h0C8, 3'h4, 16'h0190, 16'h0000, 2'h0);
		apply(OP_PEAK, 12'h0C8, 3'h4, 16'h0191, 16'h0000, 2'h3);
		rd(REG_STATUS, 32'h0000000B, RESP_OKAY);
		apply(OP_PEAK, 12'h0C8, 3'h2, 16'h0191, 16'h0000, 2'h2);
		rd(REG_STATUS, 32'h00000005, RESP_OKAY);
		apply(OP_PEAK, 12'h005, 3'h0, 16'h000B, 16'h0000, 2'h3);
		apply(OP_PEAK, 12'h005, 3'h0, 16'h000A, 16'h0000, 2'h0);
		apply(OP_PEAK, 12'h7D0, 3'h0, 16'h03E9, 16'h0000, 2'h3);
		apply(OP_PEAK, 12'h7D0, 3'h1, 16'h03E9, 16'h0000, 2'h0);
		apply(OP_PEAK, 12'h7D0, 3'h1, 16'h07D1, 16'h0000, 2'h3);
		rd(REG_STATUS, 32'h00000013, RESP_OKAY);
		rd(REG_START, 32'h000007D0, RESP_OKAY);
		wr(REG_START, 32'h00000FFF, 4'h1, RESP_OKAY);
		rd(REG_START, 32'h000007FF, RESP_OKAY);
		wr(REG_CTRL, 32'h2, 4'hF, RESP_OKAY);
		rd(REG_CTRL, 32'h1, RESP_OKAY);
		wr(REG_IRQ_STAT, 32'h3, 4'hF, RESP_OKAY);
		rd(REG_IRQ_STAT, 32'h0, RESP_OKAY);
		wr(REG_IRQ_MASK, 32'h1, 4'hF, RESP_OKAY);
		apply(OP_PEAK, 12'h0C8, 3'h0, 16'h00C8, 16'h0000, 2'h0);
		irq_chk(1'b0);
		apply(OP_PEAK, 12'h0C8, 3'h0, 16'h00C9, 16'h0000, 2'h3);
		irq_chk(1'b1);
		rd(REG_IRQ_STAT, 32'h3, RESP_OKAY);
		// Clear without lane 0 must leave both events pending
		wr(REG_IRQ_STAT, 32'h3, 4'hE, RESP_OKAY);
		rd(REG_IRQ_STAT, 32'h3, RESP_OKAY);
		wr(REG_STATUS, 32'h1F, 4'hF, RESP_OKAY);
		rd(REG_STATUS, 32'h3, RESP_OKAY);
		wr(REG_IRQ_STAT, 32'h1, 4'hF, RESP_OKAY);
		irq_chk(1'b0);
		rd(REG_IRQ_STAT, 32'h2, RESP_OKAY);
		wr(REG_IRQ_MASK, 32'h2, 4'hF, RESP_OKAY);
		irq_chk(1'b1);
		wr(REG_IRQ_MASK, 32'h0, 4'hE, RESP_OKAY);
		rd(REG_IRQ_MASK, 32'h2, RESP_OKAY);
		wr(REG_IRQ_STAT, 32'h2, 4'hF, RESP_OKAY);
		irq_chk(1'b0);
		// Mid-run reset with the trip standing must drop it and restore the settings
		rst <= 1'b1;
		repeat (2)
			@(posedge clk);
		#1;
		chk("internal_trip", {31'h0, it}, 32'h0);
		chk("general_trip_out", {31'h0, gt}, 32'h0);
		chk("irq", {31'h0, irq}, 32'h0);
		@(posedge clk);
		rst <= 1'b0;
		rd(REG_CTRL, 32'h0, RESP_OKAY);
		rd(REG_START, 32'h000000C8, RESP_OKAY);
		rd(REG_IRQ_STAT, 32'h0, RESP_OKAY);
		complete_run();
	end
endmodule // test_residual_inst_overcurrent
